// ### common/bsc_pkg.sv
//
// Overview of operation
// - Each part lands in one of nine bins, aux or out, nine primary pairs.
// - Bins tried one to the programmed count (nine at reset); first with lower < value < upper wins.
// - Auxiliary on: primary in a bin, secondary outside window gives aux.
// - Auxiliary on: primary outside all bin windows gives out.
// - One enable switches sorting; no sorting while it is off.
// - Out result raises the fail indication and fail output.
// - All ten bin result lines are driven toward the handler.
// - After trigger wait programmable 0 ms to 60 s, then start measuring.
// - Deviation monitors use stored nominal; nominal reachable only then.
// - Writing the measurement function clears automatic parameter select.
// - Level regulation on and level out of range raises failure flag.
// - Each monitor slot picks off or one derived quantity.
package bsc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS    = 12'h000;
    localparam logic [11:0] MEASUREMENT_FUNCTION_SELECT_OFS    = 12'h004;
    localparam logic [11:0] MON_OFS     = 12'h008;
    localparam logic [11:0] NOM_OFS     = 12'h00C;
    localparam logic [11:0] DELAY_OFS   = 12'h010;
    localparam logic [11:0] NBINS_OFS   = 12'h014;
    localparam logic [11:0] SEC_LO_OFS  = 12'h018;
    localparam logic [11:0] SEC_HI_OFS  = 12'h01C;
    localparam logic [11:0] STAT_OFS    = 12'h020;
    localparam logic [11:0] DEV_ABS_OFS = 12'h024;
    localparam logic [11:0] DEV_REL_OFS = 12'h028;
    localparam logic [11:0] INT_ST_OFS  = 12'h02C;
    localparam logic [11:0] INT_EN_OFS  = 12'h030;
    localparam logic [11:0] INT_CLR_OFS = 12'h034;
    localparam logic [11:0] BIN_OFS     = 12'h040;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_SORT   = 0;
    localparam int          CTRL_AUX    = 1;
    localparam int          CTRL_LVL    = 2;
    localparam int          CTRL_AUTO   = 3;
    localparam int          MON2_POS    = 8;
    localparam int          NBINS_MAX   = 9;
    localparam logic [3:0]  NBINS_RST   = 4'h9;
    localparam int          EV_DONE     = 0;
    localparam int          EV_FAIL     = 1;
    localparam int          EV_LVL      = 2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ      = 25000000;
    localparam int          MS_PER_S    = 1000;
    localparam int          DELAY_S_MAX = 60;
    localparam logic [15:0] DELAY_MS_MAX = 16'(DELAY_S_MAX * MS_PER_S);
    localparam int          CYC_PER_MS  = CLK_HZ / MS_PER_S;
    localparam int          REL_SCALE   = 10000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MON_OFF, MON_Z, MON_D, MON_Q, MON_VAC, MON_IAC, MON_DEV_ABS,
        MON_DEV_REL, MON_PH_RAD, MON_PH_DEG, MON_R, MON_X, MON_G,
        MON_B, MON_Y
    } bsc_mon_t;
    typedef enum logic [1:0] { ST_IDLE, ST_WAIT, ST_MEAS } bsc_state_t;
endpackage : bsc_pkg

// ### hw/bsc_top.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module bsc_top #(
    parameter int CYC_PER_MS = bsc_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Handler side
    input  wire logic               trig,
    output logic                    meas_start,
    output logic [9:0]              bin_out,
    output logic                    aux_out,
    output logic                    fail_indication,
    // Measurement engine
    input  wire logic               meas_done,
    input  wire logic signed [31:0] pri_val,
    input  wire logic signed [31:0] sec_val,
    input  wire logic               level_out_of_range,
    // Interrupt
    output logic                    irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0]         ctrl_r;
    logic [7:0]         measurement_function_select_r;
    bsc_pkg::bsc_mon_t  first_monitor_select_r;
    bsc_pkg::bsc_mon_t  second_monitor_select_r;
    logic signed [31:0] nom_r;
    logic [15:0]        delay_ms_r;
    logic [3:0]         nbins_r;
    logic signed [31:0] sec_lo_r;
    logic signed [31:0] sec_hi_r;
    logic signed [31:0] lo_r [9];
    logic signed [31:0] hi_r [9];
    logic signed [31:0] dev_abs_r;
    logic signed [31:0] dev_rel_r;
    logic [2:0]         int_st_r;
    logic [2:0]         int_en_r;
    logic               lvl_fail_r;
    logic               pready_r;
    logic               pslverr_r;
    logic [31:0]        prdata_r;
    logic               wr_en;
    logic [11:0]        wr_b;
    logic               dev_mon;
    logic [3:0]         bin_idx;
    logic [8:0]         in_win;
    logic               sec_ok;
    logic [2:0]         ev;

    assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign wr_b  = paddr - bsc_pkg::BIN_OFS;
    assign dev_mon = first_monitor_select_r == bsc_pkg::MON_DEV_ABS
                   || first_monitor_select_r == bsc_pkg::MON_DEV_REL
                   || second_monitor_select_r == bsc_pkg::MON_DEV_ABS
                   || second_monitor_select_r == bsc_pkg::MON_DEV_REL;

    // ------------------------------------------------------------
    // Bin windows
    // ------------------------------------------------------------
    // Strict window test
    for (genvar i = 0; i < bsc_pkg::NBINS_MAX; i++) begin : g_win
        assign in_win[i] = (4'(i) < nbins_r) && (lo_r[i] < pri_val)
                           && (pri_val < hi_r[i]);
    end
    assign sec_ok = (sec_lo_r < sec_val) && (sec_val < sec_hi_r);

    // First match from bin one upward
    always_comb begin
        bin_idx = 4'hF;
        for (int i = bsc_pkg::NBINS_MAX - 1; i >= 0; i--) begin
            if (in_win[i]) begin
                bin_idx = 4'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [11:0] a);
        logic hit;
        hit = (a <= bsc_pkg::INT_CLR_OFS) && (a[1:0] == 2'h0);
        hit = hit || ((a >= bsc_pkg::BIN_OFS) && (a[1:0] == 2'h0)
              && (a < bsc_pkg::BIN_OFS + 12'(8 * bsc_pkg::NBINS_MAX)));
        // Nominal hidden unless a deviation monitor is on
        if (a == bsc_pkg::NOM_OFS) begin
            hit = dev_mon;
        end
        return hit;
    endfunction : mapped

    function automatic logic [31:0] rd_mux(input logic [11:0] a);
        logic [31:0] d;
        logic [11:0] b;
        d = 32'h0;
        b = a - bsc_pkg::BIN_OFS;
        unique case (a)
            bsc_pkg::CTRL_OFS:    d = {28'h0, ctrl_r};
            bsc_pkg::MEASUREMENT_FUNCTION_SELECT_OFS:    d = {24'h0, measurement_function_select_r};
            bsc_pkg::MON_OFS:     d = {20'h0, second_monitor_select_r,
                                       4'h0, first_monitor_select_r};
            bsc_pkg::NOM_OFS:     d = nom_r;
            bsc_pkg::DELAY_OFS:   d = {16'h0, delay_ms_r};
            bsc_pkg::NBINS_OFS:   d = {28'h0, nbins_r};
            bsc_pkg::SEC_LO_OFS:  d = sec_lo_r;
            bsc_pkg::SEC_HI_OFS:  d = sec_hi_r;
            bsc_pkg::STAT_OFS:    d = {19'h0, lvl_fail_r, fail_indication,
                                       aux_out, bin_out};
            bsc_pkg::DEV_ABS_OFS: d = dev_abs_r;
            bsc_pkg::DEV_REL_OFS: d = dev_rel_r;
            bsc_pkg::INT_ST_OFS:  d = {29'h0, int_st_r};
            bsc_pkg::INT_EN_OFS:  d = {29'h0, int_en_r};
            default: begin
                if (a >= bsc_pkg::BIN_OFS) begin
                    d = b[2] ? hi_r[b[6:3]] : lo_r[b[6:3]];
                end
            end
        endcase
        return d;
    endfunction : rd_mux

    // Answer is prepared in the setup cycle so pready comes from a flop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else if (psel && !penable && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= ~mapped(paddr);
            prdata_r  <= (!pwrite && mapped(paddr)) ? rd_mux(paddr) : 32'h0;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Configuration writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r                        <= 4'h0;
            measurement_function_select_r <= 8'h0;
            first_monitor_select_r        <= bsc_pkg::MON_OFF;
            second_monitor_select_r       <= bsc_pkg::MON_OFF;
            nom_r                         <= 32'h0;
            delay_ms_r                    <= 16'h0;
            nbins_r                       <= bsc_pkg::NBINS_RST;
            sec_lo_r                      <= 32'h0;
            sec_hi_r                      <= 32'h0;
            int_en_r                      <= 3'h0;
            for (int i = 0; i < bsc_pkg::NBINS_MAX; i++) begin
                lo_r[i] <= 32'h0;
                hi_r[i] <= 32'h0;
            end
        end else if (wr_en) begin
            unique case (paddr)
                bsc_pkg::CTRL_OFS: ctrl_r <= pwdata[3:0];
                bsc_pkg::MEASUREMENT_FUNCTION_SELECT_OFS: begin
                    measurement_function_select_r <= pwdata[7:0];
                    ctrl_r[bsc_pkg::CTRL_AUTO] <= 1'b0;
                end
                bsc_pkg::MON_OFS: begin
                    first_monitor_select_r  <= bsc_pkg::bsc_mon_t'(
                        pwdata[3:0] > 4'hE ? 4'h0 : pwdata[3:0]);
                    second_monitor_select_r <= bsc_pkg::bsc_mon_t'(
                        pwdata[11:8] > 4'hE ? 4'h0 : pwdata[11:8]);
                end
                bsc_pkg::NOM_OFS: nom_r <= pwdata;
                // Delay clamped to the 60 s top
                bsc_pkg::DELAY_OFS: delay_ms_r <=
                    pwdata[15:0] > bsc_pkg::DELAY_MS_MAX
                    ? bsc_pkg::DELAY_MS_MAX : pwdata[15:0];
                bsc_pkg::NBINS_OFS: nbins_r <=
                    (pwdata[3:0] == 4'h0 || pwdata[3:0] > 4'h9)
                    ? nbins_r : pwdata[3:0];
                bsc_pkg::SEC_LO_OFS: sec_lo_r <= pwdata;
                bsc_pkg::SEC_HI_OFS: sec_hi_r <= pwdata;
                bsc_pkg::INT_EN_OFS: int_en_r <= pwdata[2:0];
                default: begin
                    if (paddr >= bsc_pkg::BIN_OFS) begin
                        if (wr_b[2]) begin
                            hi_r[wr_b[6:3]] <= pwdata;
                        end else begin
                            lo_r[wr_b[6:3]] <= pwdata;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Trigger delay and measurement sequence
    // ------------------------------------------------------------
    bsc_pkg::bsc_state_t state_r;
    logic [15:0]         ms_cnt_r;
    logic [31:0]         cyc_cnt_r;
    logic                sort_go;

    assign sort_go = (state_r == bsc_pkg::ST_MEAS) && meas_done;

    // Wait the programmed delay, then start
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= bsc_pkg::ST_IDLE;
            ms_cnt_r   <= 16'h0;
            cyc_cnt_r  <= 32'h0;
            meas_start <= 1'b0;
        end else begin
            meas_start <= 1'b0;
            unique case (state_r)
                bsc_pkg::ST_IDLE: begin
                    if (trig) begin
                        ms_cnt_r  <= delay_ms_r;
                        cyc_cnt_r <= 32'h0;
                        state_r   <= bsc_pkg::ST_WAIT;
                    end
                end
                bsc_pkg::ST_WAIT: begin
                    if (ms_cnt_r == 16'h0) begin
                        meas_start <= 1'b1;
                        state_r    <= bsc_pkg::ST_MEAS;
                    end else if (cyc_cnt_r == 32'(CYC_PER_MS - 1)) begin
                        cyc_cnt_r <= 32'h0;
                        ms_cnt_r  <= ms_cnt_r - 16'h1;
                    end else begin
                        cyc_cnt_r <= cyc_cnt_r + 32'h1;
                    end
                end
                bsc_pkg::ST_MEAS: begin
                    if (meas_done) begin
                        state_r <= bsc_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sorting result
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bin_out         <= 10'h000;
            aux_out         <= 1'b0;
            fail_indication <= 1'b0;
        // Outputs held low while sorting is off
        end else if (!ctrl_r[bsc_pkg::CTRL_SORT]) begin
            bin_out         <= 10'h000;
            aux_out         <= 1'b0;
            fail_indication <= 1'b0;
        end else if (sort_go) begin
            bin_out         <= 10'h000;
            aux_out         <= 1'b0;
            fail_indication <= 1'b1;
            if (bin_idx == 4'hF) begin
                bin_out[9] <= 1'b1;
            end else if (sec_ok) begin
                bin_out[bin_idx] <= 1'b1;
                fail_indication  <= 1'b0;
            // Secondary miss goes to aux bin
            end else if (ctrl_r[bsc_pkg::CTRL_AUX]) begin
                aux_out <= 1'b1;
            end else begin
                bin_out[9] <= 1'b1;
            end
        end
    end

    // Deviation from nominal, relative in hundredths of a percent
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dev_abs_r <= 32'h0;
            dev_rel_r <= 32'h0;
        end else if (meas_done && dev_mon) begin
            dev_abs_r <= pri_val - nom_r;
            dev_rel_r <= (nom_r == 32'sh0) ? 32'sh0 :
                32'((64'(pri_val - nom_r) * 64'(bsc_pkg::REL_SCALE))
                    / 64'(nom_r));
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    assign ev[bsc_pkg::EV_DONE] = sort_go && ctrl_r[bsc_pkg::CTRL_SORT];
    assign ev[bsc_pkg::EV_FAIL] = ev[bsc_pkg::EV_DONE]
                                  && !(bin_idx != 4'hF && sec_ok);
    // Regulation failure while level control is on
    assign ev[bsc_pkg::EV_LVL]  = ctrl_r[bsc_pkg::CTRL_LVL]
                                  && level_out_of_range;

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            int_st_r   <= 3'h0;
            lvl_fail_r <= 1'b0;
            irq        <= 1'b0;
        end else begin
            if (wr_en && paddr == bsc_pkg::INT_CLR_OFS) begin
                int_st_r <= (int_st_r & ~pwdata[2:0]) | ev;
            end else begin
                int_st_r <= int_st_r | ev;
            end
            lvl_fail_r <= ev[bsc_pkg::EV_LVL];
            irq        <= |(int_st_r & int_en_r);
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
endmodule : bsc_top

// ### bench/bsc_engine_model.sv
`timescale 1ns/1ps
module bsc_engine_model (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    // From the design and the bench
    input  wire logic               meas_start,
    input  wire logic signed [31:0] pri_next,
    input  wire logic signed [31:0] sec_next,
    input  wire logic [3:0]         lat,
    // Toward the design
    output logic                    meas_done,
    output logic signed [31:0]      pri_val,
    output logic signed [31:0]      sec_val
);
    // ------------------------------------------------------------
    // Measurement engine
    // ------------------------------------------------------------
    logic [3:0] cnt_r;
    logic       busy_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_r    <= 1'b0;
            cnt_r     <= 4'h0;
            meas_done <= 1'b0;
            pri_val   <= 32'h0;
            sec_val   <= 32'h0;
        end else begin
            // Values toggle outside the done pulse so stale use shows up
            meas_done <= 1'b0;
            pri_val   <= ~pri_val;
            sec_val   <= ~sec_val;
            if (meas_start) begin
                busy_r <= 1'b1;
                cnt_r  <= lat;
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r    <= 1'b0;
                meas_done <= 1'b1;
                pri_val   <= pri_next;
                sec_val   <= sec_next;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule : bsc_engine_model

// ### bench/bsc_checker.sv
`timescale 1ns/1ps
module bsc_checker (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Handler and engine
    input wire logic        meas_start,
    input wire logic        meas_done,
    input wire logic [9:0]  bin_out,
    input wire logic        aux_out,
    input wire logic        fail_indication
);
    // ------------------------------------------------------------
    // Shadow of the sort enable, taken from completed writes
    // ------------------------------------------------------------
    logic sort_en_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sort_en_r <= 1'b0;
        end else if (psel && penable && pready && pwrite
                     && paddr == bsc_pkg::CTRL_OFS) begin
            sort_en_r <= pwdata[bsc_pkg::CTRL_SORT];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    err_data_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    one_outcome_a: assert property ($onehot0({bin_out, aux_out}))
        else $error("more than one outcome");
    fail_match_a: assert property (fail_indication == (bin_out[9] || aux_out))
        else $error("fail does not follow outcome");
    start_pulse_a: assert property (meas_start |=> !meas_start)
        else $error("start longer than one cycle");
    done_result_a: assert property (meas_done && sort_en_r
        |=> $onehot({bin_out, aux_out}))
        else $error("sort gave no outcome");
    sort_off_a: assert property (!sort_en_r && !$past(sort_en_r)
        |-> {bin_out, aux_out, fail_indication} == 12'h000)
        else $error("outputs active with sorting off");
    result_hold_a: assert property (sort_en_r && $past(sort_en_r)
        && !$past(meas_done) |-> $stable(bin_out) && $stable(aux_out))
        else $error("result changed without a sort");
    cover property (meas_done && sort_en_r);
    cover property (bin_out[9]);
    cover property (aux_out);
    cover property (pslverr);
endmodule : bsc_checker

bind bsc_top bsc_checker i_bsc_checker (.sys_clk(sys_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_start(meas_start), .meas_done(meas_done), .bin_out(bin_out),
    .aux_out(aux_out), .fail_indication(fail_indication));

// ### bench/bin_sorting_comparator_test.sv
`timescale 1ns/1ps
module bin_sorting_comparator_test;
    localparam int CPM = 4;
    logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, trig = 1'b0, level_out_of_range = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic pready, pslverr, er_q, meas_start, aux_out, fail_indication;
    logic meas_done, irq, sort_en = 1'b0, aux_en = 1'b0;
    logic [9:0] bin_out;
    logic signed [31:0] pri_val, sec_val, pri_next = 0, sec_next = 0;
    logic [3:0] lat = 4'h0;
    int err_total = 0, check_count = 0, cyc = 0, nb = 9;
    int lo[9], hi[9], slo = 0, shi = 100;
    bsc_top #(.CYC_PER_MS(CPM)) i_bsc_top (.sys_clk(sys_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig(trig), .meas_start(meas_start),
        .bin_out(bin_out), .aux_out(aux_out), .irq(irq),
        .fail_indication(fail_indication), .meas_done(meas_done),
        .pri_val(pri_val), .sec_val(sec_val),
        .level_out_of_range(level_out_of_range));
    bsc_engine_model i_bsc_engine_model (.sys_clk(sys_clk), .rstn(rstn),
        .meas_start(meas_start), .pri_next(pri_next), .sec_next(sec_next),
        .lat(lat), .meas_done(meas_done), .pri_val(pri_val),
        .sec_val(sec_val));
    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        er_q = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // First matching bin wins, so scan from the top down
    function automatic logic [11:0] expect_bin(input int p, input int s);
        logic [11:0] r;
        r = 12'hA00;
        for (int i = nb - 1; i >= 0; i--)
            if (lo[i] < p && p < hi[i]) r = 12'(1 << i);
        if (r[8:0] != 9'h0 && !(slo < s && s < shi))
            r = aux_en ? 12'hC00 : 12'hA00;
        return sort_en ? r : 12'h000;
    endfunction : expect_bin
    task automatic sort(input int p, input int s);
        int n;
        logic [11:0] res;
        pri_next <= p;
        sec_next <= s;
        lat      <= 4'($urandom_range(0, 6));
        trig     <= 1'b1;
        @(posedge sys_clk);
        trig <= 1'b0;
        n = 0;
        while (meas_done !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        #1;
        res = {fail_indication, aux_out, bin_out};
        check("sort result", 32'(res), 32'(expect_bin(p, s)));
    endtask : sort
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n, m2;
        int dl[2] = '{2, 0};
        int cp[6] = '{0, 120, 150, 850, 950, 50};
        int cs[6] = '{50, 0, 100, 50, 50, 99};
        void'($urandom(26338));
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(1'b0, bsc_pkg::NBINS_OFS, 32'h0);
        check("bins reset", rd_q, 32'h9);
        apb(1'b0, 12'h03C, 32'h0);
        check("unmapped refused", 32'(er_q), 32'h1);
        for (int c = 0; c < 16; c++) begin
            m2 = 15 - c;
            apb(1'b1, bsc_pkg::MON_OFS, 32'(c | (m2 << 8)));
            apb(1'b0, bsc_pkg::MON_OFS, 32'h0);
            check("monitor", rd_q, 32'(((m2 > 14 ? 0 : m2) << 8) | (c > 14 ? 0 : c)));
        end
        apb(1'b1, bsc_pkg::NOM_OFS, 32'd500);
        check("nominal refused", 32'(er_q), 32'h1);
        apb(1'b1, bsc_pkg::MON_OFS, 32'h0700);
        apb(1'b1, bsc_pkg::NOM_OFS, 32'd500);
        check("nominal taken", 32'(er_q), 32'h0);
        apb(1'b1, bsc_pkg::CTRL_OFS, 32'h8);
        apb(1'b1, bsc_pkg::MEASUREMENT_FUNCTION_SELECT_OFS, 32'h5);
        apb(1'b0, bsc_pkg::CTRL_OFS, 32'h0);
        check("auto select cleared", rd_q, 32'h0);
        apb(1'b1, bsc_pkg::DELAY_OFS, 32'hFFFF);
        apb(1'b0, bsc_pkg::DELAY_OFS, 32'h0);
        check("delay clamp", rd_q, 32'(bsc_pkg::DELAY_MS_MAX));
        foreach (dl[j]) begin
            apb(1'b1, bsc_pkg::DELAY_OFS, 32'(dl[j]));
            trig <= 1'b1;
            @(posedge sys_clk);
            trig <= 1'b0;
            n = 0;
            while (meas_start !== 1'b1 && n < 100) begin
                @(posedge sys_clk);
                n++;
            end
            check("start delay", 32'(n >= dl[j] * CPM && n <= dl[j] * CPM + 4), 32'h1);
            repeat (20) @(posedge sys_clk);
        end
        for (int i = 0; i < 9; i++) begin
            lo[i] = i * 100;
            hi[i] = i * 100 + 150;
            apb(1'b1, bsc_pkg::BIN_OFS + 12'(8 * i), 32'(lo[i]));
            apb(1'b1, bsc_pkg::BIN_OFS + 12'(8 * i + 4), 32'(hi[i]));
        end
        apb(1'b1, bsc_pkg::SEC_LO_OFS, 32'(slo));
        apb(1'b1, bsc_pkg::SEC_HI_OFS, 32'(shi));
        apb(1'b1, bsc_pkg::INT_EN_OFS, 32'h1);
        {sort_en, aux_en} = 2'b11;
        apb(1'b1, bsc_pkg::CTRL_OFS, 32'h3);
        foreach (cp[j]) sort(cp[j], cs[j]);
        apb(1'b0, bsc_pkg::DEV_ABS_OFS, 32'h0);
        check("deviation", rd_q, 32'(50 - 500));
        apb(1'b0, bsc_pkg::DEV_REL_OFS, 32'h0);
        check("relative deviation", rd_q, 32'(-9000));
        check("irq raised", 32'(irq), 32'h1);
        apb(1'b1, bsc_pkg::INT_EN_OFS, 32'h0);
        repeat (2) @(posedge sys_clk);
        check("irq masked", 32'(irq), 32'h0);
        apb(1'b1, bsc_pkg::INT_CLR_OFS, 32'h7);
        apb(1'b0, bsc_pkg::INT_ST_OFS, 32'h0);
        check("irq status cleared", rd_q, 32'h0);
        apb(1'b1, bsc_pkg::NBINS_OFS, 32'h0);
        for (int k = 0; k < 24; k++) begin
            if (k == 12) begin
                nb = 3;
                apb(1'b1, bsc_pkg::NBINS_OFS, 32'h3);
            end
            aux_en = 1'($urandom_range(0, 1));
            apb(1'b1, bsc_pkg::CTRL_OFS, {30'h0, aux_en, 1'b1});
            sort($urandom_range(0, 1000), int'($urandom_range(0, 200)) - 50);
        end
        apb(1'b1, bsc_pkg::CTRL_OFS, 32'h5);
        level_out_of_range <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, bsc_pkg::STAT_OFS, 32'h0);
        check("level failure", 32'(rd_q[12]), 32'h1);
        level_out_of_range <= 1'b0;
        {sort_en, aux_en} = 2'b00;
        apb(1'b1, bsc_pkg::CTRL_OFS, 32'h0);
        sort(120, 50);
        tally_and_finish();
    end
endmodule : bin_sorting_comparator_test
